// >>> rtl/tdt_timer_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the timer pair.
// Assumes: 32-bit APB words, byte addresses, one register per aligned word.
// Notes:   Definitions only.
`ifndef TDT_TIMER_CFG_SVH
`define TDT_TIMER_CFG_SVH

// Register byte offsets.
`define TDT_OFF_MODE_SEL 12'h000
`define TDT_OFF_CTRL     12'h004
`define TDT_OFF_IEN      12'h008
`define TDT_OFF_CNT_LO0  12'h00C
`define TDT_OFF_CNT_HI0  12'h010
`define TDT_OFF_CNT_LO1  12'h014
`define TDT_OFF_CNT_HI1  12'h018
`define TDT_OFF_STAT   12'h01C
`define TDT_OFF_MASK   12'h020
`define TDT_LAST_INDEX 10'h008

// Mode register fields.
`define TDT_MSEL_GATE_T1 7
`define TDT_MSEL_SRC_T1  6
`define TDT_MSEL_MODE_T1 5:4
`define TDT_MSEL_GATE_T0 3
`define TDT_MSEL_SRC_T0  2
`define TDT_MSEL_MODE_T0 1:0

// Timer control register fields.
`define TDT_CTRL_RUN_T0  4
`define TDT_CTRL_OVF_T0  5
`define TDT_CTRL_RUN_T1  6
`define TDT_CTRL_OVF_T1  7

// Interrupt enable register fields.
`define TDT_IEN_EN_T0    1
`define TDT_IEN_EN_T1    3
`define TDT_IEN_RSVD   6

// Reset values.
`define TDT_RST_BYTE   8'h00
`define TDT_RST_FLAGS  2'h0

// System clock periods per machine cycle.
`define TDT_MC_PERIODS 4'hC

`endif

// >>> rtl/tdt_pkg.sv
// Purpose: Types shared by the timer pair files.
// Assumes: Constants live in tdt_timer_cfg.svh.
// Notes:   Nothing here is imported; users write tdt_pkg::name.
package tdt_pkg;

  // Operating modes held in each two-bit mode field.
  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } tdt_mode_t;

  // APB request as driven by the bus master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tdt_apb_req_t;

  // APB answer as driven by this slave.
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tdt_apb_rsp_t;

  // Result of one count step of a timer.
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ovf;
  } tdt_step_t;

  // Whole state of the timer core.
  typedef struct packed {
    logic [3:0]  pre;
    logic [7:0]  modeSel;
    logic [1:0]  run;
    logic [1:0]  tf;
    logic [7:0]  ien;
    logic [7:0]  cntLo0;
    logic [7:0]  cntHi0;
    logic [7:0]  cntLo1;
    logic [7:0]  cntHi1;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic [31:0] rdata;
  } tdt_state_t;

endpackage : tdt_pkg

// >>> rtl/tdt_pin_sync.sv
// Purpose: Two-stage synchroniser with falling edge detect for pin inputs.
// Assumes: Pins are asynchronous to core_clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
module tdt_pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } tdt_sync_st_t;

  tdt_sync_st_t state_q;
  tdt_sync_st_t state_d;

  // Shift the pins through the stages.
  always_comb begin
    state_d      = state_q;
    state_d.meta = pinIn;
    state_d.sync = state_q.meta;
    state_d.prev = state_q.sync;
  end

  // Register the stages; reset clears them.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs come from the second and third stages only.
  assign level = state_q.sync;
  assign fall  = state_q.prev & ~state_q.sync;

endmodule : tdt_pin_sync

// >>> rtl/tdt_timer_core.sv
// Purpose: Two timers with four modes, reached over APB.
// Assumes: core_clk 10 MHz, synchronous active-high reset, zero-wait APB.
// Notes:   Count pins and gate pins are synchronised before use.
// Notes on behaviour
// RULE_01 - Mode register: two mode bits, select, gate each.
// RULE_02 - Mode 0: 13-bit count, low five prescale.
// RULE_03 - Software ignores top three low bits, mode 0.
// RULE_04 - Wrap to zero sets the overflow flag.
// RULE_05 - Count only when run and gate condition hold.
// RULE_06 - Setting run never clears the count bytes.
// RULE_07 - Mode 1: full 16-bit cascade, no prescaler.
// RULE_08 - Mode 2: low byte reloads from high byte.
// RULE_09 - Mode 2 reload leaves high byte untouched.
// RULE_10 - Mode 3: timer zero splits into two bytes.
// RULE_11 - Select clear: count internal machine cycles.
// RULE_12 - Overflow flag acts as interrupt request.
// RULE_13 - Enable bits 1 and 3 gate requests.
// RULE_14 - Select set: count synchronised falling pin edges.
// RULE_15 - Machine cycle is twelve clock periods.
// RULE_16 - Vectoring to the routine clears the flag.
// RULE_17 - Timer one in mode 3 holds its count.
// RULE_18 - Split high byte always counts machine cycles.
`timescale 1ns/10ps
`include "tdt_timer_cfg.svh"
module tdt_timer_core (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire tdt_pkg::tdt_apb_req_t apbReq,
  output tdt_pkg::tdt_apb_rsp_t      apbRsp,
  input  wire logic                  ext_gate_pin_0,
  input  wire logic                  ext_gate_pin_1,
  input  wire logic                  countPin0,
  input  wire logic                  countPin1,
  input  wire logic                  intAckT0,
  input  wire logic                  intAckT1,
  output logic                       irqReqT0,
  output logic                       irqReqT1,
  output logic                       irq
);
  tdt_pkg::tdt_state_t state_q;
  tdt_pkg::tdt_state_t state_d;
  tdt_pkg::tdt_step_t  step0;
  tdt_pkg::tdt_step_t  step1;
  tdt_pkg::tdt_mode_t  mode0;
  tdt_pkg::tdt_mode_t  mode1;
  logic [3:0]          pinLevel;
  logic [3:0]          pinFall;
  logic                tick;
  logic                en0;
  logic                en1;
  logic                enSplit;
  logic                splitOvf;
  logic [1:0]          ovfEvt;
  logic                mapped;
  logic                busWr;
  logic [7:0]          wByte;
  logic [31:0]         readVal;

  // Gate pins in bits 1:0, count pins in bits 3:2.
  tdt_pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pinIn    ({countPin1, countPin0, ext_gate_pin_1, ext_gate_pin_0}),
    .level    (pinLevel),
    .fall     (pinFall)
  );

  // One count step of a timer in the given mode.
  function automatic tdt_pkg::tdt_step_t stepTimer(
    input tdt_pkg::tdt_mode_t mode,
    input logic [7:0]         hi,
    input logic [7:0]         lo,
    input logic               en
  );
    tdt_pkg::tdt_step_t r;
    r.hi  = hi;
    r.lo  = lo;
    r.ovf = 1'b0;
    if (en) begin
      case (mode)
        tdt_pkg::MODE_13BIT: begin
          // Top three low bits are left as they are.
          r.lo = {lo[7:5], lo[4:0] + 5'h01}; // see RULE_02
          if (lo[4:0] == 5'h1F) begin
            r.hi  = hi + 8'h01;
            r.ovf = (hi == 8'hFF); // see RULE_04
          end
        end
        tdt_pkg::MODE_16BIT: begin
          {r.hi, r.lo} = {hi, lo} + 16'h0001; // see RULE_07
          r.ovf        = ({hi, lo} == 16'hFFFF);
        end
        tdt_pkg::MODE_RELOAD: begin
          // High byte is only read here, never written.
          r.lo  = (lo == 8'hFF) ? hi : lo + 8'h01; // see RULE_08 RULE_09
          r.ovf = (lo == 8'hFF);
        end
        default: begin
          r.lo  = lo + 8'h01; // see RULE_10
          r.ovf = (lo == 8'hFF);
        end
      endcase
    end
    return r;
  endfunction : stepTimer

  // True when the address hits a mapped word.
  function automatic logic addrMapped(input logic [11:0] addr);
    return (addr[1:0] == 2'h0) && (addr[11:2] <= `TDT_LAST_INDEX);
  endfunction : addrMapped

  // Mode decode and count enables.
  assign mode0 = tdt_pkg::tdt_mode_t'(
                   state_q.modeSel[`TDT_MSEL_MODE_T0]); // see RULE_01
  assign mode1 = tdt_pkg::tdt_mode_t'(state_q.modeSel[`TDT_MSEL_MODE_T1]);
  assign tick  = (state_q.pre == `TDT_MC_PERIODS - 4'h1); // see RULE_15
  assign en0 = state_q.run[0]
             & (~state_q.modeSel[`TDT_MSEL_GATE_T0] | pinLevel[0]) // see RULE_05
             & (state_q.modeSel[`TDT_MSEL_SRC_T0]
                ? pinFall[2] : tick); // see RULE_11 RULE_14
  assign en1 = state_q.run[1]
             & (~state_q.modeSel[`TDT_MSEL_GATE_T1] | pinLevel[1]) // see RULE_05
             & (state_q.modeSel[`TDT_MSEL_SRC_T1] ? pinFall[3] : tick)
             & (mode1 != tdt_pkg::MODE_SPLIT); // see RULE_17
  // Split high byte uses the second run bit and machine cycles only.
  assign enSplit  = (mode0 == tdt_pkg::MODE_SPLIT) & state_q.run[1] & tick; // see RULE_18
  assign splitOvf = enSplit & (state_q.cntHi0 == 8'hFF);
  assign step0    = stepTimer(mode0, state_q.cntHi0, state_q.cntLo0, en0);
  assign step1    = stepTimer(mode1, state_q.cntHi1, state_q.cntLo1, en1);
  // Split mode hands the second flag to the high byte of timer zero.
  assign ovfEvt[0] = step0.ovf;
  assign ovfEvt[1] = (mode0 == tdt_pkg::MODE_SPLIT) ? splitOvf : step1.ovf; // see RULE_10

  // Bus decode.
  assign mapped = addrMapped(apbReq.paddr);
  assign busWr  = apbReq.psel & apbReq.penable & apbReq.pwrite & mapped;
  assign wByte  = apbReq.pwdata[7:0];

  // Read multiplexer; unlisted bits read zero.
  always_comb begin
    readVal = 32'h0000_0000;
    case (apbReq.paddr)
      `TDT_OFF_MODE_SEL: readVal[7:0] = state_q.modeSel;
      `TDT_OFF_CTRL: begin
        readVal[`TDT_CTRL_RUN_T0] = state_q.run[0];
        readVal[`TDT_CTRL_OVF_T0] = state_q.tf[0];
        readVal[`TDT_CTRL_RUN_T1] = state_q.run[1];
        readVal[`TDT_CTRL_OVF_T1] = state_q.tf[1];
      end
      `TDT_OFF_IEN:     readVal[7:0] = state_q.ien;
      `TDT_OFF_CNT_LO0: readVal[7:0] = state_q.cntLo0;
      `TDT_OFF_CNT_HI0: readVal[7:0] = state_q.cntHi0;
      `TDT_OFF_CNT_LO1: readVal[7:0] = state_q.cntLo1;
      `TDT_OFF_CNT_HI1: readVal[7:0] = state_q.cntHi1;
      `TDT_OFF_STAT: readVal[1:0] = state_q.stat;
      `TDT_OFF_MASK: readVal[1:0] = state_q.mask;
      default:       readVal = 32'h0000_0000;
    endcase
  end

  // Next state: prescaler, counters, registers and flags.
  always_comb begin
    state_d = state_q;
    state_d.pre = tick ? 4'h0 : state_q.pre + 4'h1; // see RULE_15
    state_d.cntLo0 = step0.lo;
    state_d.cntHi0 = enSplit ? state_q.cntHi0 + 8'h01 : step0.hi;
    state_d.cntLo1 = step1.lo;
    state_d.cntHi1 = step1.hi;
    if (apbReq.psel && !apbReq.penable) begin
      state_d.rdata = readVal;
    end
    // A bus write overrides a count step in the same cycle.
    if (busWr) begin
      case (apbReq.paddr)
        `TDT_OFF_MODE_SEL: state_d.modeSel = wByte; // see RULE_01
        `TDT_OFF_CTRL: begin
          // Run bits touch no count byte.
          state_d.run[0] = wByte[`TDT_CTRL_RUN_T0]; // see RULE_06
          state_d.run[1] = wByte[`TDT_CTRL_RUN_T1];
          state_d.tf[0]  = wByte[`TDT_CTRL_OVF_T0];
          state_d.tf[1]  = wByte[`TDT_CTRL_OVF_T1];
        end
        `TDT_OFF_IEN: begin
          state_d.ien                = wByte;
          state_d.ien[`TDT_IEN_RSVD] = 1'b0;
        end
        `TDT_OFF_CNT_LO0: state_d.cntLo0 = wByte;
        `TDT_OFF_CNT_HI0: state_d.cntHi0 = wByte;
        `TDT_OFF_CNT_LO1: state_d.cntLo1 = wByte;
        `TDT_OFF_CNT_HI1: state_d.cntHi1 = wByte;
        `TDT_OFF_STAT: state_d.stat = state_q.stat & ~wByte[1:0];
        `TDT_OFF_MASK: state_d.mask = wByte[1:0];
        default:       state_d.mask = state_q.mask;
      endcase
    end
    // Vectoring clears a flag; a new overflow wins over any clear.
    if (intAckT0) begin
      state_d.tf[0] = 1'b0; // see RULE_16
    end
    if (intAckT1) begin
      state_d.tf[1] = 1'b0; // see RULE_16
    end
    state_d.tf   = state_d.tf | ovfEvt; // see RULE_04
    state_d.stat = state_d.stat | ovfEvt;
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q       <= '0;
      state_q.modeSel <= `TDT_RST_BYTE;
      state_q.ien   <= `TDT_RST_BYTE;
      state_q.tf    <= `TDT_RST_FLAGS;
      state_q.stat  <= `TDT_RST_FLAGS;
    end else begin
      state_q <= state_d;
    end
  end

  // Interrupt requests and bus answer.
  assign irqReqT0 = state_q.tf[0]
                  & state_q.ien[`TDT_IEN_EN_T0]; // see RULE_12 RULE_13
  assign irqReqT1 = state_q.tf[1]
                  & state_q.ien[`TDT_IEN_EN_T1]; // see RULE_12 RULE_13
  assign irq      = |(state_q.stat & state_q.mask);
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = apbReq.psel & apbReq.penable & ~mapped;
  assign apbRsp.prdata  = state_q.rdata;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  property p_tick_period;
    tick |-> ##12 tick;
  endproperty
  a_tick_period: assert property (p_tick_period) // see RULE_15
    else $error("Machine cycle is not twelve clocks.");

  property p_stop_holds;
    (!state_q.run[0] && !busWr) |=> $stable(state_q.cntLo0);
  endproperty
  a_stop_holds: assert property (p_stop_holds) // see RULE_05
    else $error("Stopped timer zero low byte changed.");

  property p_gate_holds;
    (state_q.modeSel[`TDT_MSEL_GATE_T0] && !pinLevel[0] && !busWr)
      |=> $stable(state_q.cntLo0);
  endproperty
  a_gate_holds: assert property (p_gate_holds) // see RULE_05
    else $error("Gated timer zero advanced with gate low.");

  property p_mode0_wrap;
    (en0 && mode0 == tdt_pkg::MODE_13BIT && state_q.cntHi0 == 8'hFF
      && state_q.cntLo0[4:0] == 5'h1F && !busWr)
      |=> (state_q.cntHi0 == 8'h00 && state_q.cntLo0[4:0] == 5'h00
           && state_q.tf[0]);
  endproperty
  a_mode0_wrap: assert property (p_mode0_wrap) // see RULE_02
    else $error("Mode 0 wrap did not clear count and set flag.");

  property p_mode1_wrap;
    (en0 && mode0 == tdt_pkg::MODE_16BIT
      && {state_q.cntHi0, state_q.cntLo0} == 16'hFFFF && !busWr)
      |=> ({state_q.cntHi0, state_q.cntLo0} == 16'h0000 && state_q.tf[0]);
  endproperty
  a_mode1_wrap: assert property (p_mode1_wrap) // see RULE_07
    else $error("Mode 1 wrap did not clear count and set flag.");

  property p_reload;
    (en0 && mode0 == tdt_pkg::MODE_RELOAD && state_q.cntLo0 == 8'hFF
      && !busWr)
      |=> (state_q.cntLo0 == $past(state_q.cntHi0)
           && $stable(state_q.cntHi0)
           && state_q.tf[0]);
  endproperty
  a_reload: assert property (p_reload) // see RULE_08
    else $error("Mode 2 reload wrong.");

  property p_t1_split_hold;
    (mode1 == tdt_pkg::MODE_SPLIT && !busWr)
      |=> ($stable(state_q.cntLo1) && $stable(state_q.cntHi1));
  endproperty
  a_t1_split_hold: assert property (p_t1_split_hold) // see RULE_17
    else $error("Timer one moved in mode 3.");

  property p_ack_clear;
    (intAckT0 && !ovfEvt[0] && !busWr) |=> !state_q.tf[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear) // see RULE_16
    else $error("Vectoring did not clear timer zero flag.");

  property p_irq_gate;
    (state_q.tf[1] && !state_q.ien[`TDT_IEN_EN_T1]) |-> !irqReqT1;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // see RULE_13
    else $error("Disabled timer one request reached the core.");

  c_reload:  cover property (en0 && mode0 == tdt_pkg::MODE_RELOAD
                             && state_q.cntLo0 == 8'hFF);
  c_split:   cover property (splitOvf);
  c_gated:   cover property (en0 && state_q.modeSel[`TDT_MSEL_GATE_T0]);

endmodule : tdt_timer_core

// >>> testbench/tdt_core_model.sv
// Purpose: Core and pin model around the timer pair.
// Assumes: Driven by tb_top on core_clk.
// Notes:   Acks follow an enabled request by one cycle.
`timescale 1ns/10ps
module tdt_core_model (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic gateLevel,
  input  wire logic pulseEn,
  input  wire logic ackEn,
  input  wire logic irqReqT0,
  input  wire logic irqReqT1,
  output logic      ext_gate_pin_0,
  output logic      ext_gate_pin_1,
  output logic      countPin0,
  output logic      countPin1,
  output logic      intAckT0,
  output logic      intAckT1
);
  logic [2:0] div_q;

  // Gate pins follow the level the bench asks for.
  assign ext_gate_pin_0 = gateLevel;
  assign ext_gate_pin_1 = gateLevel;

  // Count pins idle high and fall once every sixteen cycles when enabled.
  always_ff @(posedge core_clk) begin
    if (reset || !pulseEn) begin
      div_q <= 3'h0;
      countPin0 <= 1'b1;
      countPin1 <= 1'b1;
    end else begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h7) begin
        countPin0 <= ~countPin0;
        countPin1 <= ~countPin1;
      end
    end
  end

  // The core vectors to a routine one cycle after an enabled request.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      intAckT0 <= 1'b0;
      intAckT1 <= 1'b0;
    end else begin
      intAckT0 <= irqReqT0 && ackEn && !intAckT0;
      intAckT1 <= irqReqT1 && ackEn && !intAckT1;
    end
  end
endmodule : tdt_core_model

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the timer pair over APB.
// Assumes: 10 MHz clock, zero-wait slave.
// Notes:   Each wrap test stops the timer right after its overflow.
`timescale 1ns/10ps
`include "tdt_timer_cfg.svh"
module tb_top;
  logic                  core_clk;
  logic                  reset;
  tdt_pkg::tdt_apb_req_t req;
  tdt_pkg::tdt_apb_rsp_t rsp;
  logic                  gateLevel;
  logic                  pulseEn;
  logic                  ackEn;
  logic                  gp0, gp1, cp0, cp1, ack0, ack1;
  logic                  irqReqT0, irqReqT1, irq;
  logic                  lastErr;
  logic [7:0]            rd;
  int                    error_cnt;
  int                    n_compared;

  tdt_timer_core uut (.core_clk(core_clk), .reset(reset), .apbReq(req),
    .apbRsp(rsp), .ext_gate_pin_0(gp0), .ext_gate_pin_1(gp1),
    .countPin0(cp0), .countPin1(cp1), .intAckT0(ack0), .intAckT1(ack1),
    .irqReqT0(irqReqT0), .irqReqT1(irqReqT1), .irq(irq));

  tdt_core_model model (.core_clk(core_clk), .reset(reset),
    .gateLevel(gateLevel), .pulseEn(pulseEn), .ackEn(ackEn),
    .irqReqT0(irqReqT0), .irqReqT1(irqReqT1), .ext_gate_pin_0(gp0),
    .ext_gate_pin_1(gp1), .countPin0(cp0), .countPin1(cp1),
    .intAckT0(ack0), .intAckT1(ack1));

  // Clock of 100 ns period.
  always #50 core_clk = ~core_clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // Compares a seen value with the expected one.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, entered just after a rising edge.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [7:0] d);
    int n;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
             pwdata: {24'h0, d}};
    @(posedge core_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    rd = rsp.prdata[7:0];
    lastErr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge core_clk);
    if (n >= 16) begin
      error_cnt++;
      stop_test();
    end
  endtask : xfer

  // Reads a register and compares the bits under a mask.
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e,
                        input logic [7:0] m);
    xfer(1'b0, a, 8'h00);
    check(rd & m, e & m);
  endtask : rd_chk

  // Lets registered interrupt outputs settle.
  task automatic settle();
    repeat (2) @(posedge core_clk);
  endtask : settle

  // Presets a timer, runs it to overflow, stops it and checks the result.
  task automatic wrap(input logic [7:0] modeByte, run, input logic [11:0] thA,
                      tlA, input logic [7:0] th, tl, eth, etl, tlM,
                      input logic hold);
    int n;
    logic [7:0] flag;
    flag = run << 1;
    gateLevel <= !hold;
    pulseEn <= !hold;
    xfer(1'b1, `TDT_OFF_STAT, 8'h03);
    xfer(1'b1, `TDT_OFF_MASK, 8'h03);
    xfer(1'b1, `TDT_OFF_MODE_SEL, modeByte);
    xfer(1'b1, thA, th);
    xfer(1'b1, tlA, tl);
    xfer(1'b1, `TDT_OFF_CTRL, run);
    if (hold) begin
      repeat (40) @(posedge core_clk);
      check({7'h0, irq}, 8'h00);
      rd_chk(tlA, tl, tlM);
      gateLevel <= 1'b1;
      pulseEn <= 1'b1;
    end
    n = 0;
    while (irq !== 1'b1 && n < 64) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 64) begin
      error_cnt++;
      stop_test();
    end
    check({7'h0, irq}, 8'h01);
    xfer(1'b1, `TDT_OFF_CTRL, flag);
    rd_chk(thA, eth, 8'hFF);
    rd_chk(tlA, etl, tlM);
    rd_chk(`TDT_OFF_CTRL, flag, 8'hFF);
    rd_chk(`TDT_OFF_STAT, {6'h0, run[6], run[4]}, 8'hFF);
    xfer(1'b1, `TDT_OFF_MASK, 8'h00);
    settle();
    check({7'h0, irq}, 8'h00);
    xfer(1'b1, `TDT_OFF_MASK, 8'h03);
    settle();
    check({7'h0, irq}, 8'h01);
    xfer(1'b1, `TDT_OFF_STAT, 8'h03);
    settle();
    check({7'h0, irq}, 8'h00);
    $display("wrap test done, mode byte %h", modeByte);
  endtask : wrap

  // Enables a set flag as a request, then lets the core acknowledge it.
  task automatic ien_test(input logic [7:0] en);
    xfer(1'b1, `TDT_OFF_IEN, 8'h00);
    settle();
    check({6'h0, irqReqT1, irqReqT0}, 8'h00);
    xfer(1'b1, `TDT_OFF_IEN, en);
    settle();
    check({6'h0, irqReqT1, irqReqT0}, {6'h0, en[3], en[1]});
    ackEn <= 1'b1;
    repeat (4) @(posedge core_clk);
    ackEn <= 1'b0;
    rd_chk(`TDT_OFF_CTRL, 8'h00, 8'hFF);
    check({6'h0, irqReqT1, irqReqT0}, 8'h00);
    $display("enable test done, enable byte %h", en);
  endtask : ien_test

  // Bounds the whole run.
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end

  // Main sequence.
  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    req = '0;
    gateLevel = 1'b0;
    pulseEn = 1'b0;
    ackEn = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i <= 8; i++) begin
      rd_chk(12'(i * 4), 8'h00, 8'hFF);
    end
    xfer(1'b0, 12'h024, 8'h00);
    check({7'h0, lastErr}, 8'h01);
    check(rd, 8'h00);
    xfer(1'b1, `TDT_OFF_MODE_SEL, 8'hA5);
    rd_chk(`TDT_OFF_MODE_SEL, 8'hA5, 8'hFF);
    xfer(1'b1, `TDT_OFF_IEN, 8'hFF);
    rd_chk(`TDT_OFF_IEN, 8'hBF, 8'hFF);
    $display("register test done");
    wrap(8'h00, 8'h10, `TDT_OFF_CNT_HI0, `TDT_OFF_CNT_LO0, 8'hFF, 8'h1F,
         8'h00, 8'h00, 8'h1F, 1'b0);
    ien_test(8'h02);
    wrap(8'h0A, 8'h10, `TDT_OFF_CNT_HI0, `TDT_OFF_CNT_LO0, 8'hF0, 8'hFF,
         8'hF0, 8'hF0, 8'hFF, 1'b1);
    wrap(8'h06, 8'h10, `TDT_OFF_CNT_HI0, `TDT_OFF_CNT_LO0, 8'h80, 8'hFF,
         8'h80, 8'h80, 8'hFF, 1'b1);
    wrap(8'h10, 8'h40, `TDT_OFF_CNT_HI1, `TDT_OFF_CNT_LO1, 8'hFF, 8'hFF,
         8'h00, 8'h00, 8'hFF, 1'b0);
    ien_test(8'h08);
    xfer(1'b1, `TDT_OFF_CNT_LO1, 8'hFF);
    xfer(1'b1, `TDT_OFF_CNT_HI1, 8'hFF);
    wrap(8'h33, 8'h40, `TDT_OFF_CNT_HI0, `TDT_OFF_CNT_LO0, 8'hFF, 8'h55,
         8'h00, 8'h55, 8'hFF, 1'b0);
    rd_chk(`TDT_OFF_CNT_LO1, 8'hFF, 8'hFF);
    stop_test();
  end
endmodule : tb_top
